// ---- i2c_bit_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "i2c_host_map.svh"
module i2c_bit_engine #(
  parameter int QTR_CYC = 63
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   cmd_valid,
  input  wire i2c_host_pkg::bus_cmd_t cmd,
  output logic                        cmd_ready,
  output logic                        rsp_valid,
  output i2c_host_pkg::bus_rsp_t      rsp,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe_n,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_n
);
  import i2c_host_pkg::*;
  localparam int QW = $clog2(QTR_CYC);

  if (QTR_CYC < 2) begin : g_bad_qtr
    $error("QTR_CYC must be at least 2");
  end

  eng_state_t      st_q;
  bus_cmd_t        cmd_q;
  logic [1:0]      ph_q;
  logic [3:0]      bit_q;
  logic [7:0]      sh_q;
  logic            ack_q;
  logic [QW-1:0]   q_q;
  logic            scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic            tick, adv;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // ----------------------------------------
  // Quarter bit divider
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_q <= '0;
    else if (st_q == E_IDLE || q_q == '0)
      q_q <= QW'(QTR_CYC - 1);
    else
      q_q <= q_q - 1'b1;
  end

  assign tick = (st_q != E_IDLE) && (q_q == '0);
  // Target holding SCL low stalls the high phase
  assign adv = tick && !(ph_q == `PH_HIGH && !scl_s_q);
  assign cmd_ready = (st_q == E_IDLE);

  // Open-drain levels are always low when driven
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Condition and bit sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q      <= E_IDLE;
      cmd_q     <= '0;
      ph_q      <= '0;
      bit_q     <= '0;
      sh_q      <= '0;
      ack_q     <= 1'b1;
      rsp_valid <= 1'b0;
      rsp       <= '0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (st_q == E_IDLE && cmd_valid)
      begin
        cmd_q <= cmd;
        sh_q  <= cmd.data;
        ph_q  <= '0;
        bit_q <= '0;
        case (cmd.op)
          OP_START: st_q <= E_START;
          OP_STOP:  st_q <= E_STOP;
          default:  st_q <= E_BIT;
        endcase
      end
      else if (adv)
      begin
        ph_q <= ph_q + 1'b1;
        case (ph_q)
          `PH_SETUP:
            case (st_q)
              E_START: sda_oe_n <= 1'b1;
              E_STOP:  sda_oe_n <= 1'b0;
              default:
                if (bit_q == `BIT_ACK)
                  sda_oe_n <= (cmd_q.op == OP_READ) ? cmd_q.ack : 1'b1;
                else
                  sda_oe_n <= (cmd_q.op == OP_WRITE) ? sh_q[7] : 1'b1;
            endcase
          `PH_RISE:
            scl_oe_n <= 1'b1;
          `PH_HIGH:
            case (st_q)
              E_START: sda_oe_n <= 1'b0;
              E_STOP:  sda_oe_n <= 1'b1;
              default:
                if (bit_q == `BIT_ACK)
                  ack_q <= sda_s_q;
                else
                  sh_q <= {sh_q[6:0], sda_s_q};
            endcase
          default:
          begin
            if (st_q != E_STOP)
              scl_oe_n <= 1'b0;
            if (st_q == E_BIT && bit_q != `BIT_ACK)
              bit_q <= bit_q + 1'b1;
            else
            begin
              st_q      <= E_IDLE;
              rsp_valid <= 1'b1;
              rsp       <= '{data: sh_q, ack: ack_q};
            end
          end
        endcase
      end
    end
  end
endmodule // i2c_bit_engine
`default_nettype wire

// ---- i2c_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_dev_model #(
  parameter logic [6:0] DEV_ID = 7'h2a
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      pull,
  output logic      stretch
);
  logic [31:0] mem [0:255];
  logic [31:0] nv  [0:255];
  logic [63:0] dat;
  logic [23:0] cw;
  logic [7:0]  b, crc, s, ix;
  // Fold one byte into the checksum
  function automatic logic [7:0] upd(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Eight bits in, MSB first
  task automatic rx();
    for (int i = 7; i >= 0; i--) @(posedge scl) b[i] = sda;
    crc = upd(crc, b);
  endtask
  // Hold the ninth bit low, stretching the clock briefly as the hold begins
  task automatic ack();
    @(negedge scl) pull = 1'b1;
    stretch = 1'b1;
    #600 stretch = 1'b0;
    @(negedge scl) pull = 1'b0;
  endtask
  // Eight bits out, then the host's acknowledge clock
  task automatic tx(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      pull = ~v[i];
      @(negedge scl);
    end
    pull = 1'b0;
    @(posedge scl);
    @(negedge scl);
  endtask
  // One packet per start; the control word survives a stop
  initial
  begin
    pull = 1'b0;
    stretch = 1'b0;
    forever
    begin
      @(negedge sda iff scl === 1'b1);
      s = crc;
      crc = 8'hff;
      rx();
      if (b[7:1] !== DEV_ID) continue;
      ack();
      if (b[0])
      begin
        crc = upd(s, b);
        dat = {mem[ix + 8'h2], mem[ix]};
        for (int k = 0; k < (2 << cw[21:20]); k++)
        begin
          crc = upd(crc, dat[8*k +: 8]);
          tx(dat[8*k +: 8]);
        end
        if (cw[22]) tx(crc);
        continue;
      end
      for (int k = 2; k >= 0; k--)
      begin
        rx();
        ack();
        cw[8*k +: 8] = b;
      end
      ix = cw[7:0];
      if (cw[23]) continue;
      dat = '0;
      for (int k = 0; k < (2 << cw[21:20]); k++)
      begin
        rx();
        ack();
        dat[8*k +: 8] = b;
      end
      if (cw[22]) rx();
      if (cw[22]) ack();
      // A further byte instead of the stop discards the write
      @(posedge scl);
      @(posedge sda or negedge scl);
      if (scl === 1'b1 && (!cw[22] || crc == 8'h00) && cw[19:12] == 8'h00)
      begin
        mem[ix] = dat[31:0];
        if (cw[21]) mem[ix + 8'h2] = dat[63:32];
        if (ix == 8'hea && dat[31:0] == 32'h8a500000) nv = mem;
        if (ix == 8'hea && dat[31:0] == 32'h40000000) mem = nv;
      end
    end
  end
endmodule  // i2c_dev_model
`default_nettype wire

// ---- i2c_host_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "i2c_host_map.svh"
// ----------------------------------------
// Notes on behaviour
// - Hold off 300 ms after commit command
// - Load command word recognised at 0xea
// - Hold off 100 ms after load command
// - Leave 100 us between bus bytes
// - Packet opens with target id, write
// - Control bit 23 selects read or write
// - Bit 22 checksum, bits 21-20 length
// - Payload bytes go least significant first
// - Write checksum byte ends the packet
// - Read uses restart and read address
// - Host acknowledges every returned byte
// - Read checksum byte, then last acknowledge
// - Every transaction ends with stop
// - Commit command word copies shadow to storage
// - CRC8 polynomial 0x07, seed 0xff
// ----------------------------------------
module i2c_host_ctrl #(
  parameter int COMMIT_WAIT_CYC =
    (`COMMIT_WAIT_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int LOAD_WAIT_CYC =
    (`LOAD_WAIT_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int GAP_CYC = (`BYTE_GAP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int QTR_CYC = (`BIT_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  import i2c_host_pkg::*;
  localparam int HW = $clog2(COMMIT_WAIT_CYC + 1);
  localparam int GW = $clog2(GAP_CYC + 1);

  if (LOAD_WAIT_CYC < 1 || COMMIT_WAIT_CYC < LOAD_WAIT_CYC || GAP_CYC < 1
      || GAP_CYC > 65535) begin : g_bad_cfg
    $error("Wait or gap counts out of range");
  end

  xfer_cfg_t     cfg_q;
  logic [19:0]   addr_q;
  logic [6:0]    tid_q;
  logic [63:0]   wdata_q, rdata_q;
  logic [3:0]    flags_q, flag_set, flag_clr;
  step_t         step_q;
  logic          issued_q, nack_q;
  logic [2:0]    idx_q, last_idx;
  logic [7:0]    crc_q;
  logic [GW-1:0] gap_q;
  logic [HW-1:0] hold_q;
  logic [15:0]   since_q;
  logic [31:0]   rd_mux;
  logic [23:0]   cw;
  bus_cmd_t      eng_cmd;
  bus_rsp_t      eng_rsp;
  logic          eng_ready, eng_done, issue, step_done;
  logic          wr_en, go_wr, go_ok, len_bad, commit_hit, load_hit;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      `REG_CMD, `REG_ADDR, `REG_TID, `REG_WD0, `REG_WD1,
      `REG_RD0, `REG_RD1, `REG_STAT: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic step_writes(input step_t s);
    case (s)
      S_ADDRW, S_CW, S_WDATA, S_WCRC, S_ADDRR: step_writes = 1'b1;
      default: step_writes = 1'b0;
    endcase
  endfunction

  // CRC8 over one byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    return r;
  endfunction

  // Index of last payload byte per length code
  function automatic logic [2:0] last_byte(input logic [1:0] len);
    case (len)
      2'h0:    last_byte = 3'h1;
      2'h1:    last_byte = 3'h3;
      default: last_byte = 3'h7;
    endcase
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_en   = psel && penable && pready && pwrite && reg_mapped(paddr);
  assign go_wr   = wr_en && (paddr == `REG_CMD) && pwdata[`CMD_GO];
  assign len_bad = (pwdata[`CMD_LEN] == `LEN_RSVD);
  assign go_ok   = go_wr && (step_q == S_IDLE) && (hold_q == '0) && !len_bad;

  // Read data mux
  always_comb
  begin
    case (paddr)
      `REG_CMD:  rd_mux = {25'h0, cfg_q.split, cfg_q.payload_length_code, 1'b0,
                           cfg_q.crc_en, cfg_q.operation_direction_bit, 1'b0};
      `REG_ADDR: rd_mux = {12'h0, addr_q};
      `REG_TID:  rd_mux = {25'h0, tid_q};
      `REG_WD0:  rd_mux = wdata_q[31:0];
      `REG_WD1:  rd_mux = wdata_q[63:32];
      `REG_RD0:  rd_mux = rdata_q[31:0];
      `REG_RD1:  rd_mux = rdata_q[63:32];
      `REG_STAT: rd_mux = {26'h0, hold_q != '0, flags_q, step_q != S_IDLE};
      default:   rd_mux = 32'h0;
    endcase
  end

  // Zero-wait answer in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !reg_mapped(paddr);
      if (psel && !penable)
        prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // Transfer setup, frozen while a transfer runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q   <= '0;
      addr_q  <= '0;
      tid_q   <= '0;
      wdata_q <= '0;
    end
    else if (wr_en && step_q == S_IDLE)
    begin
      case (paddr)
        `REG_CMD:  cfg_q <= '{split: pwdata[`CMD_SPLIT],
                              payload_length_code: pwdata[`CMD_LEN],
                              crc_en: pwdata[`CMD_CRC],
                              operation_direction_bit: pwdata[`CMD_DIR]};
        `REG_ADDR: addr_q <= pwdata[19:0];
        `REG_TID:  tid_q <= pwdata[6:0];
        `REG_WD0:  wdata_q[31:0] <= pwdata;
        `REG_WD1:  wdata_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Sticky status flags, write one to clear
  // ----------------------------------------
  assign flag_clr = (wr_en && paddr == `REG_STAT) ? pwdata[`STAT_CLR] : 4'h0;

  always_comb
  begin
    flag_set           = 4'h0;
    flag_set[`FL_DONE] = step_done && (step_q == S_STOP);
    flag_set[`FL_NACK] = step_done && step_writes(step_q) && eng_rsp.ack;
    flag_set[`FL_CRC]  = step_done && (step_q == S_RCRC) && (eng_rsp.data != crc_q);
    flag_set[`FL_LEN]  = go_wr && (step_q == S_IDLE) && len_bad;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= 4'h0;
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end

  // ----------------------------------------
  // Byte command builder
  // ----------------------------------------
  // Control word: direction, checksum, length, section, page, offset
  assign cw = {cfg_q.operation_direction_bit, cfg_q.crc_en,
               cfg_q.payload_length_code, addr_q};
  assign last_idx  = last_byte(cfg_q.payload_length_code);
  assign issue     = (step_q != S_IDLE) && !issued_q && eng_ready && (gap_q == '0);
  assign step_done = issued_q && eng_done;

  always_comb
  begin
    eng_cmd = '{op: OP_WRITE, data: 8'h00, ack: 1'b0};
    case (step_q)
      S_START, S_RSTART: eng_cmd.op = OP_START;
      S_MIDSTOP, S_STOP: eng_cmd.op = OP_STOP;
      S_ADDRW:           eng_cmd.data = {tid_q, 1'b0};
      S_CW:
        case (idx_q)
          3'h0:    eng_cmd.data = cw[23:16];
          3'h1:    eng_cmd.data = cw[15:8];
          default: eng_cmd.data = cw[7:0];
        endcase
      // Low word then high word, each low byte first
      S_WDATA:           eng_cmd.data = wdata_q[{idx_q, 3'b000} +: 8];
      S_WCRC:            eng_cmd.data = crc_q;
      S_ADDRR:           eng_cmd.data = {tid_q, 1'b1};
      S_RDATA, S_RCRC:   eng_cmd.op = OP_READ;
      default: ;
    endcase
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q   <= S_IDLE;
      issued_q <= 1'b0;
      idx_q    <= 3'h0;
      crc_q    <= `CRC_SEED;
      nack_q   <= 1'b0;
      rdata_q  <= '0;
    end
    else if (go_ok)
    begin
      step_q <= S_START;
      idx_q  <= 3'h0;
      crc_q  <= `CRC_SEED;
      nack_q <= 1'b0;
    end
    else
    begin
      if (issue)
        issued_q <= 1'b1;
      if (step_done)
      begin
        issued_q <= 1'b0;
        if (step_q != S_WCRC && step_q != S_RCRC && eng_cmd.op != OP_START
            && eng_cmd.op != OP_STOP)
          crc_q <= crc8(crc_q, eng_rsp.data);
        if (step_writes(step_q) && eng_rsp.ack)
        begin
          nack_q <= 1'b1;
          step_q <= S_STOP;
        end
        else
        begin
          case (step_q)
            S_START:   step_q <= S_ADDRW;
            S_ADDRW:   step_q <= S_CW;
            S_CW:
              if (idx_q == `CW_LAST)
              begin
                idx_q <= 3'h0;
                if (!cfg_q.operation_direction_bit)
                  step_q <= S_WDATA;
                else
                  step_q <= cfg_q.split ? S_MIDSTOP : S_RSTART;
              end
              else
                idx_q <= idx_q + 1'b1;
            S_WDATA:
              if (idx_q == last_idx)
              begin
                idx_q  <= 3'h0;
                step_q <= cfg_q.crc_en ? S_WCRC : S_STOP;
              end
              else
                idx_q <= idx_q + 1'b1;
            S_WCRC:    step_q <= S_STOP;
            S_MIDSTOP: step_q <= S_RSTART;
            S_RSTART:  step_q <= S_ADDRR;
            S_ADDRR:   step_q <= S_RDATA;
            S_RDATA:
            begin
              rdata_q[{idx_q, 3'b000} +: 8] <= eng_rsp.data;
              if (idx_q == last_idx)
              begin
                idx_q  <= 3'h0;
                step_q <= cfg_q.crc_en ? S_RCRC : S_STOP;
              end
              else
                idx_q <= idx_q + 1'b1;
            end
            S_RCRC:    step_q <= S_STOP;
            S_STOP:    step_q <= S_IDLE;
            default:   step_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  // Inter-byte gap counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= '0;
    else if (step_done)
      gap_q <= GW'(GAP_CYC);
    else if (gap_q != '0)
      gap_q <= gap_q - 1'b1;
  end

  // ----------------------------------------
  // Storage command hold-off
  // ----------------------------------------
  assign commit_hit = step_done && (step_q == S_STOP) && !cfg_q.operation_direction_bit
                      && !nack_q && (cfg_q.payload_length_code == `LEN_32)
                      && (addr_q == `STORE_CMD_ADDR)
                      && (wdata_q[31:0] == `STORE_COMMIT);
  assign load_hit   = step_done && (step_q == S_STOP) && !cfg_q.operation_direction_bit
                      && !nack_q && (cfg_q.payload_length_code == `LEN_32)
                      && (addr_q == `STORE_CMD_ADDR)
                      && (wdata_q[31:0] == `STORE_LOAD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= '0;
    else if (commit_hit)
      hold_q <= HW'(COMMIT_WAIT_CYC);
    else if (load_hit)
      hold_q <= HW'(LOAD_WAIT_CYC);
    else if (hold_q != '0)
      hold_q <= hold_q - 1'b1;
  end

  // Cycles since the last finished bus step, for checking only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      since_q <= 16'hffff;
    else if (step_done)
      since_q <= 16'h0000;
    else if (since_q != 16'hffff)
      since_q <= since_q + 1'b1;
  end

  // ----------------------------------------
  // Bus bit engine
  // ----------------------------------------
  i2c_bit_engine #(
    .QTR_CYC (QTR_CYC)
  ) u_engine (
    .pclk      (pclk),
    .presetn   (presetn),
    .cmd_valid (issue),
    .cmd       (eng_cmd),
    .cmd_ready (eng_ready),
    .rsp_valid (eng_done),
    .rsp       (eng_rsp),
    .scl_i     (scl_i),
    .scl_o     (scl_o),
    .scl_oe_n  (scl_oe_n),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_n  (sda_oe_n)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_commit_hold: assert property (commit_hit |=> hold_q == HW'(COMMIT_WAIT_CYC))
    else $error("commit hold-off not loaded");
  a_load_hold: assert property (load_hit |=> hold_q == HW'(LOAD_WAIT_CYC))
    else $error("load hold-off not loaded");
  a_start_blocked: assert property (issue && step_q == S_START |-> hold_q == '0)
    else $error("start issued during hold-off");
  a_byte_gap: assert property (issue && step_q != S_START |-> since_q >= GAP_CYC)
    else $error("byte gap too short");
  a_first_byte: assert property (step_done && step_q == S_ADDRW
    |-> eng_rsp.data == {tid_q, 1'b0})
    else $error("first byte not target write");
  a_dir_bit: assert property (step_done && step_q == S_CW && idx_q == 3'h0
    |-> eng_rsp.data[7] == cfg_q.operation_direction_bit)
    else $error("direction bit wrong");
  a_len_rsvd: assert property (go_wr && step_q == S_IDLE && len_bad
    |=> step_q == S_IDLE && flags_q[`FL_LEN])
    else $error("reserved length accepted");
  a_lsb_first: assert property (step_done && step_q == S_WDATA && idx_q == 3'h0
    |-> eng_rsp.data == wdata_q[7:0])
    else $error("payload not low byte first");
  a_read_turn: assert property (step_done && step_q == S_CW && idx_q == `CW_LAST
    && cfg_q.operation_direction_bit && !eng_rsp.ack
    |=> step_q == (cfg_q.split ? S_MIDSTOP : S_RSTART))
    else $error("read phase not restarted");
  a_read_ack: assert property (step_done && (step_q == S_RDATA || step_q == S_RCRC)
    |-> !eng_rsp.ack)
    else $error("read byte not acknowledged");
  a_done_stop: assert property ($rose(flags_q[`FL_DONE]) |-> $past(step_q) == S_STOP)
    else $error("done without stop");
  a_crc_seed: assert property (issue && step_q == S_ADDRW |-> crc_q == `CRC_SEED)
    else $error("crc not seeded");

  c_write_done: cover property (step_done && step_q == S_STOP && !cfg_q.operation_direction_bit);
  c_read_crc: cover property (step_done && step_q == S_RCRC);
  c_split_read: cover property (step_done && step_q == S_MIDSTOP);
  c_nack: cover property (flag_set[`FL_NACK]);
endmodule // i2c_host_ctrl
`default_nettype wire

// ---- i2c_host_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_host_ctrl_tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, scl_oe_n, sda_oe_n, pull, stretch, scl_lo, sda_lo;
  int          err_count, total_checks, cyc;
  wire         scl = scl_oe_n & ~stretch;  // Pulled up when released
  wire         sda = sda_oe_n & ~pull;
  i2c_host_ctrl #(.COMMIT_WAIT_CYC(50), .LOAD_WAIT_CYC(20), .GAP_CYC(4), .QTR_CYC(4)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_lo), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_lo),
    .sda_oe_n(sda_oe_n));
  i2c_dev_model #(.DEV_ID(7'h2a)) partner (.scl(scl), .sda(sda), .pull(pull),
    .stretch(stretch));
  initial forever #20 pclk = ~pclk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) err_count++;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Wait out hold-off, clear flags, launch, poll for done
  task automatic xfer(input logic [19:0] a, input logic [31:0] w, input logic [7:0] c);
    do apb(1'b0, 8'h1c, 32'h0); while (rd[5] !== 1'b0);
    apb(1'b1, 8'h1c, 32'h1e);
    apb(1'b1, 8'h04, {12'h0, a});
    apb(1'b1, 8'h0c, w);
    apb(1'b1, 8'h00, {24'h0, c});
    do apb(0, 8'h1c, 32'h0); while (rd[1] !== 1'b1);
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h1c, 32'h0);
    chk("stat after reset", rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped slverr", {31'h0, err}, 32'h1);
    chk("drive levels", {30'h0, scl_lo, sda_lo}, 32'h0);
    apb(1'b1, 8'h08, 32'h2a);
  endtask
  task automatic t_word();
    xfer(20'h00080, 32'h1234abcd, 8'h15);
    chk("crc write flags", rd & 32'h1e, 32'h2);
    chk("stored word", partner.mem[8'h80], 32'h1234abcd);
    xfer(20'h00080, 32'h0, 8'h17);
    chk("crc read flags", rd & 32'h1e, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    chk("read word", rd, 32'h1234abcd);
  endtask
  task automatic t_long();
    apb(1'b1, 8'h10, 32'h89abcdef);
    xfer(20'h00084, 32'h01234567, 8'h21);
    chk("second word", partner.mem[8'h86], 32'h89abcdef);
    xfer(20'h00084, 32'h0, 8'h63);
    apb(1'b0, 8'h18, 32'h0);
    chk("split read high", rd, 32'h89abcdef);
    xfer(20'h00088, 32'h5555beef, 8'h01);
    chk("short write", partner.mem[8'h88], 32'h0000beef);
  endtask
  task automatic t_refuse();
    apb(1'b1, 8'h08, 32'h2b);
    xfer(20'h00080, 32'h0, 8'h15);
    chk("wrong id nack", rd & 32'h1e, 32'h6);
    apb(1'b1, 8'h08, 32'h2a);
    xfer(20'h10080, 32'h0, 8'h11);
    chk("other section", partner.mem[8'h80], 32'h1234abcd);
    apb(1'b1, 8'h1c, 32'h1e);
    apb(1'b1, 8'h00, 32'h31);
    apb(1'b0, 8'h1c, 32'h0);
    chk("reserved length", rd & 32'h1e, 32'h10);
  endtask
  task automatic t_store();
    xfer(20'h000ea, 32'h8a500000, 8'h11);
    chk("commit hold-off", {31'h0, rd[5]}, 32'h1);
    chk("committed", partner.nv[8'h80], 32'h1234abcd);
    xfer(20'h00080, 32'h0, 8'h11);
    xfer(20'h000ea, 32'h40000000, 8'h11);
    chk("load hold-off", {31'h0, rd[5]}, 32'h1);
    xfer(20'h00080, 32'h0, 8'h13);
    apb(1'b0, 8'h14, 32'h0);
    chk("loaded word", rd, 32'h1234abcd);
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_word();
    t_long();
    t_refuse();
    t_store();
    tally_and_finish();
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000) err_count++;
    if (cyc == 60000) tally_and_finish();
  end
endmodule  // i2c_host_ctrl_tb_top
`default_nettype wire

// ---- i2c_host_map.svh ----
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH
// Register byte offsets
`define REG_CMD        8'h00
`define REG_ADDR       8'h04
`define REG_TID        8'h08
`define REG_WD0        8'h0c
`define REG_WD1        8'h10
`define REG_RD0        8'h14
`define REG_RD1        8'h18
`define REG_STAT       8'h1c
// Command register fields
`define CMD_GO         0
`define CMD_DIR        1
`define CMD_CRC        2
`define CMD_LEN        5:4
`define CMD_SPLIT      6
`define LEN_RSVD       2'h3
`define LEN_32         2'h1
// Sticky flag positions and status clear field
`define FL_DONE        0
`define FL_NACK        1
`define FL_CRC         2
`define FL_LEN         3
`define STAT_CLR       4:1
// Far device constants
`define STORE_CMD_ADDR 20'h000ea
`define STORE_COMMIT   32'h8a500000
`define STORE_LOAD     32'h40000000
`define CRC_SEED       8'hff
`define CRC_POLY       8'h07
`define CW_LAST        3'h2
// Bit phases and ack slot
`define PH_SETUP       2'h0
`define PH_RISE        2'h1
`define PH_HIGH        2'h2
`define BIT_ACK        4'h8
// Timing
`define CLK_PERIOD_NS  40
`define COMMIT_WAIT_MS 300
`define LOAD_WAIT_MS   100
`define BYTE_GAP_US    100
`define BIT_PERIOD_NS  10000
`endif

// ---- i2c_host_pkg.sv ----
package i2c_host_pkg;
  typedef enum logic [1:0] {
    OP_START = 2'b00, OP_STOP = 2'b01, OP_WRITE = 2'b10, OP_READ = 2'b11
  } bus_op_t;
  typedef struct packed {
    bus_op_t    op;
    logic [7:0] data;
    logic       ack;
  } bus_cmd_t;
  typedef struct packed {
    logic [7:0] data;
    logic       ack;
  } bus_rsp_t;
  typedef struct packed {
    logic       split;
    logic [1:0] payload_length_code;
    logic       crc_en;
    logic       operation_direction_bit;
  } xfer_cfg_t;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_START = 2'b01, E_BIT = 2'b10, E_STOP = 2'b11
  } eng_state_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_START = 4'b0001, S_ADDRW = 4'b0010, S_CW = 4'b0011,
    S_WDATA = 4'b0100, S_WCRC = 4'b0101, S_MIDSTOP = 4'b0110, S_RSTART = 4'b0111,
    S_ADDRR = 4'b1000, S_RDATA = 4'b1001, S_RCRC = 4'b1010, S_STOP = 4'b1011
  } step_t;
endpackage
